// *** usb_buf_lpm_regs.sv ***
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
module usb_buf_lpm_regs
  import usb_buf_lpm_pkg::*;
(
  input  logic                   aclk,
  input  logic                   aresetn,
  input  logic [31:0]            s_axi_awaddr,
  input  logic                   s_axi_awvalid,
  output logic                   s_axi_awready,
  input  logic [31:0]            s_axi_wdata,
  input  logic [3:0]             s_axi_wstrb,
  input  logic                   s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  logic                   s_axi_bready,
  input  logic [31:0]            s_axi_araddr,
  input  logic                   s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  logic                   s_axi_rready,
  input  lpm_token_t             lpm_token,
  input  logic                   lpm_enable,
  output lpm_reply_t             lpm_reply,
  input  logic [N_ENDPOINTS-1:0] active_clear,
  input  logic [N_ENDPOINTS-1:0] abort_done,
  output logic [N_ENDPOINTS-1:0] abort_request,
  output logic [31:0]            endpoint_list_base,
  output logic [9:0]             data_area_page,
  output logic [3:0]             resume_duration_required,
  output logic [N_SLOTS-1:0]     current_slot,
  output logic [N_SLOTS-1:0]     dual_slot_enable,
  output logic                   irq
);

  typedef struct packed {
    logic [23:0]            list_base;
    logic [9:0]             data_page;
    logic [3:0]             dur_received;
    logic [3:0]             dur_required;
    logic                   pending;
    logic [N_ENDPOINTS-1:0] abort;
    logic [7:0]             slot;
    logic [7:0]             mode;
    logic [N_ENDPOINTS-1:0] status;
    logic [N_ENDPOINTS-1:0] mask;
    lpm_reply_t             reply;
    logic                   irq;
  } regs_t;

  regs_t       r_q;
  regs_t       r_d;
  reg_wr_t     wr;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] wval;
  logic [31:0] wbits;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[8*b +: 8] = data[8*b +: 8];
      end
    end
    return v;
  endfunction

  // Only stored fields are placed into the word, so reserved bits always read zero.
  function automatic logic [31:0] read_word(input logic [31:0] addr, input regs_t r);
    logic [31:0] v;
    v = REG_RESET;
    case (addr)
      ADDR_LIST_BASE:  v[LIST_BASE_LSB +: 24] = r.list_base;
      ADDR_DATA_PAGE:  v[DATA_PAGE_LSB +: 10] = r.data_page;
      ADDR_LINK_POWER: begin
        v[RCV_DUR_LSB +: 4] = r.dur_received;
        v[REQ_DUR_LSB +: 4] = r.dur_required;
        v[PENDING_BIT]      = r.pending;
      end
      ADDR_ABORT:      v[N_ENDPOINTS-1:0] = r.abort;
      ADDR_SLOT_SEL:   v[SLOT_LSB +: 8] = r.slot;
      ADDR_SLOT_MODE:  v[SLOT_LSB +: 8] = r.mode;
      ADDR_IRQ_STATUS: v[N_ENDPOINTS-1:0] = r.status;
      ADDR_IRQ_MASK:   v[N_ENDPOINTS-1:0] = r.mask;
      default:         v = REG_RESET;
    endcase
    return v;
  endfunction

  axil_reg_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  assign rd_data = read_word(rd_addr, r_q);
  assign wval    = merge(read_word(wr.addr, r_q), wr.data, wr.strb);
  // Set and clear registers act only on written bytes, so unwritten bytes count as zero.
  assign wbits   = merge(REG_RESET, wr.data, wr.strb);

  always_comb begin
    r_d             = r_q;
    r_d.reply.valid = 1'b0;
    if (lpm_token.valid) begin
      r_d.dur_received = lpm_token.duration;
      if (lpm_enable) begin
        // The reply is only chosen here; a disabled LPM leaves the answer to the engine.
        r_d.reply.valid = 1'b1;
        r_d.reply.nyet  = r_q.pending;
      end
    end
    // Hardware retires aborts first so a software abort in the same cycle survives.
    r_d.abort = r_q.abort & ~abort_done;
    for (int i = SLOT_LSB; i < N_SLOTS; i++) begin
      if (active_clear[i] && r_q.mode[i-SLOT_LSB]) begin
        r_d.slot[i-SLOT_LSB] = ~r_q.slot[i-SLOT_LSB];
      end
    end
    if (wr.valid) begin
      case (wr.addr)
        ADDR_LIST_BASE:  r_d.list_base = wval[LIST_BASE_LSB +: 24];
        ADDR_DATA_PAGE:  r_d.data_page = wval[DATA_PAGE_LSB +: 10];
        ADDR_LINK_POWER: begin
          r_d.dur_required = wval[REQ_DUR_LSB +: 4];
          r_d.pending      = wval[PENDING_BIT];
        end
        ADDR_ABORT:      r_d.abort = r_d.abort | wbits[N_ENDPOINTS-1:0];
        ADDR_SLOT_SEL:   r_d.slot = wval[SLOT_LSB +: 8];
        ADDR_SLOT_MODE:  r_d.mode = wval[SLOT_LSB +: 8];
        ADDR_IRQ_STATUS: r_d.status = r_q.status & ~wbits[N_ENDPOINTS-1:0];
        ADDR_IRQ_MASK:   r_d.mask = wval[N_ENDPOINTS-1:0];
        default:         r_d.irq = r_q.irq;
      endcase
    end
    // Events are merged after the clear so one arriving with the clear is kept.
    r_d.status = r_d.status | active_clear | abort_done;
    r_d.irq    = |(r_d.status & r_d.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign lpm_reply                = r_q.reply;
  assign abort_request            = r_q.abort;
  assign endpoint_list_base       = {r_q.list_base, 8'h00};
  assign data_area_page           = r_q.data_page;
  assign resume_duration_required = r_q.dur_required;
  // Serving an abort leaves the slot named here unchanged; abort_done never touches current_slot.
  assign current_slot             = {r_q.slot, 2'h0};
  assign dual_slot_enable         = {r_q.mode, 2'h0};
  assign irq                      = r_q.irq;

  logic wr_slot;
  logic wr_abort;
  logic wr_full;
  logic rd_take;

  assign wr_slot  = wr.valid && (wr.addr == ADDR_SLOT_SEL);
  assign wr_abort = wr.valid && (wr.addr == ADDR_ABORT);
  assign wr_full  = wr.valid && (wr.strb == 4'hf);
  assign rd_take  = s_axi_arvalid && s_axi_arready;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_LIST_WRITE: assert property (
    wr_full && wr.addr == ADDR_LIST_BASE |=>
      endpoint_list_base == ($past(wr.data) & 32'hffff_ff00))
    else $error("List base write not stored with low byte zero.");

  AST_PAGE_WRITE: assert property (
    wr_full && wr.addr == ADDR_DATA_PAGE |=> data_area_page == $past(wr.data[31:22]))
    else $error("Data page write not stored.");

  AST_DUR_CAPTURE: assert property (
    lpm_token.valid |=> r_q.dur_received == $past(lpm_token.duration))
    else $error("Resume duration from token not captured.");

  AST_DUR_REQUIRED: assert property (
    wr_full && wr.addr == ADDR_LINK_POWER |=> resume_duration_required == $past(wr.data[7:4]))
    else $error("Required resume duration not stored.");

  AST_NYET_REPLY: assert property (
    lpm_token.valid && lpm_enable && r_q.pending |=> lpm_reply.valid && lpm_reply.nyet)
    else $error("Pending data did not produce a NYET reply.");

  AST_ACK_REPLY: assert property (
    lpm_token.valid && lpm_enable && !r_q.pending |=> lpm_reply.valid && !lpm_reply.nyet)
    else $error("Idle LPM token did not produce an ACK reply.");

  AST_NO_REPLY_DISABLED: assert property (
    !(lpm_token.valid && lpm_enable) |=> !lpm_reply.valid)
    else $error("LPM reply without an enabled token.");

  AST_ABORT_SET: assert property (
    wr_abort && wr_full |=> (abort_request & $past(wr.data[29:0])) == $past(wr.data[29:0]))
    else $error("Abort write did not raise the request.");

  AST_ABORT_RETIRE: assert property (
    (|abort_done) && !wr_abort |=> (abort_request & $past(abort_done)) == '0)
    else $error("Retired abort bit still set.");

  AST_SLOT_KEPT: assert property (
    (|abort_done) && !(|active_clear) && !wr_slot |=> $stable(current_slot))
    else $error("Abort retirement changed the current slot.");

  AST_EVENT_IRQ: assert property (
    (|(active_clear | abort_done)) |=>
      (r_q.status & $past(active_clear | abort_done)) == $past(active_clear | abort_done))
    else $error("Active bit fall did not set its status bit.");

  AST_SLOT_TOGGLE: assert property (
    !wr_slot |=> current_slot[9:2] ==
      ($past(current_slot[9:2]) ^ ($past(active_clear[9:2]) & $past(dual_slot_enable[9:2]))))
    else $error("Current slot bit did not follow the slot mode.");

  AST_EP0_FIXED: assert property (
    current_slot[1:0] == 2'h0 && dual_slot_enable[1:0] == 2'h0)
    else $error("Control endpoint slot bits not zero.");

  AST_IRQ_LEVEL: assert property (
    irq == |(r_q.status & r_q.mask))
    else $error("Interrupt output disagrees with status and mask.");

  AST_UNMAPPED_READ: assert property (
    s_axi_arvalid && s_axi_arready && !is_mapped(s_axi_araddr) |=>
      s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == RESP_SLVERR)
    else $error("Unmapped read not answered with zero and an error.");

  AST_SLOT_WRITE: assert property (
    wr_full && wr_slot |=> current_slot[9:2] == $past(wr.data[9:2]))
    else $error("Current slot write not stored.");

  AST_MODE_WRITE: assert property (
    wr_full && wr.addr == ADDR_SLOT_MODE |=>
      dual_slot_enable[9:2] == $past(wr.data[9:2]))
    else $error("Slot mode write not stored.");

  AST_SINGLE_KEPT: assert property (
    !wr_slot |=> ((current_slot[9:2] ^ $past(current_slot[9:2])) &
                  ~$past(dual_slot_enable[9:2])) == 8'h00)
    else $error("Single slot endpoint changed its current slot.");

  AST_PENDING_WRITE: assert property (
    wr_full && wr.addr == ADDR_LINK_POWER |=> r_q.pending == $past(wr.data[PENDING_BIT]))
    else $error("Pending data bit not stored.");

  AST_DUR_HOLD: assert property (
    !lpm_token.valid |=> $stable(r_q.dur_received))
    else $error("Received resume duration changed without a token.");

  AST_NO_STRAY_ABORT: assert property (
    !wr_abort |=> (abort_request & ~$past(abort_request)) == '0)
    else $error("Abort request rose without a software write.");

  AST_MASK_WRITE: assert property (
    wr_full && wr.addr == ADDR_IRQ_MASK |=> r_q.mask == $past(wr.data[N_ENDPOINTS-1:0]))
    else $error("Interrupt mask write not stored.");

  // A clear that meets a new event keeps the event, so only quiet bits must drop.
  AST_STATUS_CLEAR: assert property (
    wr_full && wr.addr == ADDR_IRQ_STATUS |=>
      (r_q.status & $past(wr.data[N_ENDPOINTS-1:0] & ~(active_clear | abort_done))) == '0)
    else $error("Written status bits not cleared.");

  AST_LIST_LOW_ZERO: assert property (
    rd_take && s_axi_araddr == ADDR_LIST_BASE |=> s_axi_rdata[7:0] == 8'h00)
    else $error("List base low byte read as nonzero.");

  AST_PAGE_LOW_ZERO: assert property (
    rd_take && s_axi_araddr == ADDR_DATA_PAGE |=> s_axi_rdata[21:0] == 22'h0)
    else $error("Data page low bits read as nonzero.");

  AST_LINK_RESERVED: assert property (
    rd_take && s_axi_araddr == ADDR_LINK_POWER |=> s_axi_rdata[31:9] == 23'h0)
    else $error("Link power reserved bits read as nonzero.");

  AST_ABORT_RESERVED: assert property (
    rd_take && s_axi_araddr == ADDR_ABORT |=> s_axi_rdata[31:30] == 2'h0)
    else $error("Abort register reserved bits read as nonzero.");

  AST_SLOT_RESERVED: assert property (
    rd_take && (s_axi_araddr == ADDR_SLOT_SEL || s_axi_araddr == ADDR_SLOT_MODE) |=>
      s_axi_rdata[31:10] == 22'h0 && s_axi_rdata[1:0] == 2'h0)
    else $error("Slot register fixed bits read as nonzero.");

  AST_UNMAPPED_WRITE: assert property (
    wr.valid && !is_mapped(wr.addr) |=>
      $stable(endpoint_list_base) && $stable(data_area_page) && $stable(r_q.mask) &&
      $stable(resume_duration_required) && $stable(dual_slot_enable))
    else $error("Unmapped write changed a register.");

  COV_NYET:  cover property (lpm_token.valid && lpm_enable && r_q.pending);
  COV_ABORT: cover property (wr_abort ##[1:20] (|abort_done));
  COV_TOGGLE: cover property ((|(active_clear[9:2] & dual_slot_enable[9:2])) && !wr_slot);
  COV_IRQ:   cover property ($rose(irq));

endmodule

// *** usb_buf_lpm_pkg.sv ***
package usb_buf_lpm_pkg;

  localparam logic [31:0] ADDR_LIST_BASE  = 32'h4008_0008;
  localparam logic [31:0] ADDR_DATA_PAGE  = 32'h4008_000c;
  localparam logic [31:0] ADDR_LINK_POWER = 32'h4008_0010;
  localparam logic [31:0] ADDR_ABORT      = 32'h4008_0014;
  localparam logic [31:0] ADDR_SLOT_SEL   = 32'h4008_0018;
  localparam logic [31:0] ADDR_SLOT_MODE  = 32'h4008_001c;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4008_0030;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h4008_0034;

  localparam int          LIST_BASE_LSB   = 8;
  localparam int          DATA_PAGE_LSB   = 22;
  localparam int          RCV_DUR_LSB     = 0;
  localparam int          REQ_DUR_LSB     = 4;
  localparam int          PENDING_BIT     = 8;
  localparam int          SLOT_LSB        = 2;
  localparam int          N_ENDPOINTS     = 30;
  localparam int          N_SLOTS         = 10;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } reg_wr_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] duration;
  } lpm_token_t;

  typedef struct packed {
    logic valid;
    logic nyet;
  } lpm_reply_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;

  typedef struct packed {
    logic        aw_have;
    logic [31:0] awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    rd_state_t   rd_state;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } slave_state_t;

  localparam slave_state_t SLAVE_RESET = '{rd_state: RD_IDLE, awready: 1'b1, wready: 1'b1,
                                           default: '0};

  function automatic logic is_mapped(input logic [31:0] addr);
    return (addr == ADDR_LIST_BASE) || (addr == ADDR_DATA_PAGE) || (addr == ADDR_LINK_POWER) ||
           (addr == ADDR_ABORT) || (addr == ADDR_SLOT_SEL) || (addr == ADDR_SLOT_MODE) ||
           (addr == ADDR_IRQ_STATUS) || (addr == ADDR_IRQ_MASK);
  endfunction

endpackage

// *** axil_reg_slave.sv ***
`timescale 1ns/10ps
module axil_reg_slave
  import usb_buf_lpm_pkg::*;
(
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [31:0] s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [31:0] s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  output reg_wr_t     wr,
  output logic [31:0] rd_addr,
  input  logic [31:0] rd_data
);

  slave_state_t s_q;
  slave_state_t s_d;

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  // The one-hot state bits are the handshake flops themselves, so no decode sits on the pins.
  assign s_axi_arready = s_q.rd_state[0];
  assign s_axi_rvalid  = s_q.rd_state[1];
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign rd_addr       = s_axi_araddr;

  // Address and data are held separately so either may arrive first.
  always_comb begin
    s_d = s_q;
    wr = '{valid: s_q.aw_have & s_q.w_have & ~s_q.bvalid, addr: s_q.awaddr,
           data: s_q.wdata, strb: s_q.wstrb};
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (wr.valid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = is_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_have & ~s_d.bvalid;
    case (s_q.rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          s_d.rd_state = RD_RESP;
          s_d.rdata    = rd_data;
          s_d.rresp    = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          s_d.rd_state = RD_IDLE;
        end
      end
      default: s_d.rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= SLAVE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// *** usb_engine_model.sv ***
`timescale 1ns/10ps
module usb_engine_model
  import usb_buf_lpm_pkg::*;
(
  input  logic                   aclk,
  input  logic                   aresetn,
  input  logic                   tok_go,
  input  logic [3:0]             tok_dur,
  input  logic [N_ENDPOINTS-1:0] clr_go,
  input  logic                   slow,
  input  logic [N_ENDPOINTS-1:0] abort_request,
  output lpm_token_t             lpm_token,
  output logic [N_ENDPOINTS-1:0] active_clear,
  output logic [N_ENDPOINTS-1:0] abort_done
);
  logic [2:0] wait_q;

  // The duration lines change on every idle cycle, so a design that samples
  // them outside a token cannot pass by luck.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpm_token    <= '0;
      active_clear <= '0;
      abort_done   <= '0;
      wait_q       <= '0;
    end else begin
      lpm_token.valid    <= tok_go;
      lpm_token.duration <= tok_go ? tok_dur : ~lpm_token.duration;
      active_clear       <= clr_go;
      abort_done         <= '0;
      if (abort_request == '0) begin
        wait_q <= '0;
      end else if (wait_q == (slow ? 3'h7 : 3'h1)) begin
        abort_done <= abort_request;
        wait_q     <= '0;
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule

// *** usb_device_buffer_lpm_regs_tb_top.sv ***
`timescale 1ns/10ps
module usb_device_buffer_lpm_regs_tb_top
  import usb_buf_lpm_pkg::*;
;
  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic [31:0]            awaddr = '0;
  logic                   awvalid = 1'b0;
  logic [31:0]            wdata = '0;
  logic [3:0]             wstrb = 4'hf;
  logic                   wvalid = 1'b0;
  logic                   bready = 1'b0;
  logic [31:0]            araddr = '0;
  logic                   arvalid = 1'b0;
  logic                   rready = 1'b0;
  logic                   lpm_enable = 1'b0;
  logic                   tok_go = 1'b0;
  logic [3:0]             tok_dur = 4'h0;
  logic [N_ENDPOINTS-1:0] clr_go = '0;
  logic                   slow = 1'b0;
  logic                   awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata, endpoint_list_base;
  lpm_token_t             lpm_token;
  lpm_reply_t             lpm_reply;
  logic [N_ENDPOINTS-1:0] active_clear, abort_done, abort_request;
  logic [9:0]             data_area_page, current_slot, dual_slot_enable;
  logic [3:0]             resume_duration_required;
  logic                   got, nyet;
  int                     failures = 0;
  int                     n_compared = 0;
  logic [31:0]            addrs [8] = '{ADDR_LIST_BASE, ADDR_DATA_PAGE, ADDR_LINK_POWER,
                                        ADDR_SLOT_SEL, ADDR_SLOT_MODE, ADDR_ABORT,
                                        ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  logic [31:0]            ones_read [5] = '{32'hffff_ff00, 32'hffc0_0000, 32'h0000_01f0,
                                            32'h0000_03fc, 32'h0000_03fc};

  usb_buf_lpm_regs u_usb_buf_lpm_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lpm_token(lpm_token), .lpm_enable(lpm_enable), .lpm_reply(lpm_reply),
    .active_clear(active_clear), .abort_done(abort_done), .abort_request(abort_request),
    .endpoint_list_base(endpoint_list_base), .data_area_page(data_area_page),
    .resume_duration_required(resume_duration_required), .current_slot(current_slot),
    .dual_slot_enable(dual_slot_enable), .irq(irq));

  usb_engine_model u_usb_engine_model (
    .aclk(aclk), .aresetn(aresetn), .tok_go(tok_go), .tok_dur(tok_dur), .clr_go(clr_go),
    .slow(slow), .abort_request(abort_request), .lpm_token(lpm_token),
    .active_clear(active_clear), .abort_done(abort_done));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask

  task automatic give_up(input string what);
    $display("[ERR] %s expected answer seen timeout", what);
    failures++;
    final_report();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 60);
    if (bvalid !== 1'b1) give_up("write response");
    chk("bresp", {30'h0, exp_resp}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 60);
    if (rvalid !== 1'b1) give_up("read response");
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, exp_resp}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  // A reply is a one-cycle pulse, so every edge of the window is looked at.
  task automatic token(input logic [3:0] dur);
    @(posedge aclk);
    tok_go  <= 1'b1;
    tok_dur <= dur;
    @(posedge aclk);
    tok_go <= 1'b0;
    got  = 1'b0;
    nyet = 1'b0;
    repeat (6) begin
      @(posedge aclk);
      if (lpm_reply.valid === 1'b1) begin
        got  = 1'b1;
        nyet = lpm_reply.nyet;
      end
    end
  endtask

  initial begin
    forever #4 aclk = ~aclk;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(addrs[i], REG_RESET, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(addrs[i], 32'hffff_ffff, RESP_OKAY);
      rd(addrs[i], ones_read[i], RESP_OKAY);
    end
    chk("list base", 32'hffff_ff00, endpoint_list_base);
    chk("data page", 32'h3ff, {22'h0, data_area_page});
    chk("resume required", 32'hf, {28'h0, resume_duration_required});
    chk("slot mode", 32'h3fc, {22'h0, dual_slot_enable});
    wr(ADDR_ABORT, 32'hc000_0000, RESP_OKAY);
    rd(ADDR_ABORT, 32'h0, RESP_OKAY);
    wr(32'h4008_0020, 32'h1, RESP_SLVERR);
    rd(32'h4008_0020, 32'h0, RESP_SLVERR);
    lpm_enable <= 1'b1;
    wr(ADDR_LINK_POWER, 32'h0000_01a0, RESP_OKAY);
    token(4'h9);
    chk("nyet reply", 32'h3, {30'h0, got, nyet});
    rd(ADDR_LINK_POWER, 32'h0000_01a9, RESP_OKAY);
    wr(ADDR_LINK_POWER, 32'h0000_0030, RESP_OKAY);
    token(4'h2);
    chk("ack reply", 32'h2, {30'h0, got, nyet});
    lpm_enable <= 1'b0;
    token(4'h7);
    chk("reply while unsupported", 32'h0, {31'h0, got});
    rd(ADDR_LINK_POWER, 32'h0000_0037, RESP_OKAY);
    wr(ADDR_SLOT_MODE, 32'h0000_0014, RESP_OKAY);
    wr(ADDR_SLOT_SEL, 32'h0000_0008, RESP_OKAY);
    @(posedge aclk);
    clr_go <= 30'h0000_001c;
    @(posedge aclk);
    clr_go <= '0;
    repeat (3) @(posedge aclk);
    chk("current slot", 32'h01c, {22'h0, current_slot});
    rd(ADDR_SLOT_SEL, 32'h0000_001c, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h0000_001c, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0000_0010, RESP_OKAY);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_001c, RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // First a slow engine on a single slot endpoint, then a prompt one on a dual slot one.
    for (int k = 0; k < 2; k++) begin
      slow <= (k == 0);
      wr(ADDR_ABORT, (k == 0) ? 32'h0000_0008 : 32'h0000_0010, RESP_OKAY);
      if (k == 0) rd(ADDR_ABORT, 32'h0000_0008, RESP_OKAY);
      for (int n = 0; n < 30 && abort_request !== '0; n++) @(posedge aclk);
      chk("abort request", 32'h0, {2'h0, abort_request});
      chk("slot kept", 32'h01c, {22'h0, current_slot});
      rd(ADDR_IRQ_STATUS, (k == 0) ? 32'h8 : 32'h18, RESP_OKAY);
    end
    // Byte strobes: only the written byte may clear status or change the list base.
    wstrb <= 4'h2;
    wr(ADDR_IRQ_STATUS, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h0000_0018, RESP_OKAY);
    wr(ADDR_LIST_BASE, 32'h0000_5500, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_LIST_BASE, 32'hffff_5500, RESP_OKAY);
    chk("list base bytes", 32'hffff_5500, endpoint_list_base);
    final_report();
  end
endmodule
